// file: src/ds3_tx_framer_overhead_error_insert.sv
// ds3 transmit overhead generation, alarm/idle insertion and error insertion
// Contract
// - parity generation overwrites p-bits, even with framing disabled
// - idle bit inserts idle payload pattern
// - m23, c-gen enabled: c-bits forced zero
// - m23, c-gen disabled: c-bits pass through
// - block-error defeat: c4x carry inverted forced bit
// - auto block error from receive parity/framing errors
// - defect defeat: x-bits carry inverted forced bit
// - auto remote defect from receive alarms
// - frame gen disabled: overhead passes through
// - alarm bit inserts ais payload pattern
// - c-parity errors: enable gates, continuous or single
// - block errors: enable gates, continuous or single
// - p-parity errors: enable gates, continuous or single
// - type field picks f, m, sef, oomf
// - framing errors only while enable set
// - single-error bit rising edge inserts one error
// - many toggles per opportunity give one error
// - source select picks external trigger input
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module ds3_tx_framer_overhead_error_insert (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ds3_tx_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ds3_tx_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [ds3_tx_pkg::DATA_W-1:0] regRdata,
  input wire logic cbitMode,
  input wire logic rxParityErr,
  input wire logic rxFramingErr,
  input wire logic rxAlarm,
  input wire logic extErrorTriggerIn,
  input wire ds3_tx_pkg::ds3_bit_s inStream,
  output ds3_tx_pkg::ds3_bit_s outStream
);
  import ds3_tx_pkg::*;

  tx_state_s q;
  tx_state_s s;

  logic parityGenEnable;
  logic txIdleInsert;
  logic cbitGenDisable;
  logic forcedBlockError;
  logic autoBlockErrorDefeat;
  logic forcedRemoteDefect;
  logic autoRemoteDefectDefeat;
  logic frameGenDisable;
  logic txAlarmSignalInsert;
  logic cparErrContinuous;
  logic cparErrEnable;
  logic blockErrContinuous;
  logic blockErrEnable;
  logic pparErrContinuous;
  logic pparErrEnable;
  logic framingErrEnable;
  logic manualSourceSelect;
  logic genOn;
  logic mf;
  logic trig;
  logic extRise;
  logic bitTrigRise;
  logic aisBit;
  logic idleBit;
  logic febeBit;
  logic rdiBit;
  logic [DATA_W-1:0] status;

  // pending single error: waits for the next multiframe opportunity
  function automatic logic nextPend(input logic pend, input logic en,
                                    input logic cont, input logic tr,
                                    input logic mfs);
    return en & ((pend & ~mfs) | (tr & ~cont & ~mfs));
  endfunction : nextPend

  // active error: armed for one whole multiframe at its start
  function automatic logic nextAct(input logic act, input logic pend,
                                   input logic en, input logic cont,
                                   input logic tr, input logic mfs);
    return mfs ? (en & (pend | tr | cont)) : (act & en);
  endfunction : nextAct

  assign parityGenEnable = q.ctl[PARITY_GEN_ENABLE_BIT];
  assign txIdleInsert = q.ctl[TX_IDLE_INSERT_BIT];
  assign cbitGenDisable = q.ctl[CBIT_GEN_DISABLE_BIT];
  assign forcedBlockError = q.ctl[FORCED_BLOCK_ERROR_BIT];
  assign autoBlockErrorDefeat = q.ctl[AUTO_BLOCK_ERROR_DEFEAT_BIT];
  assign forcedRemoteDefect = q.ctl[FORCED_REMOTE_DEFECT_BIT];
  assign autoRemoteDefectDefeat = q.ctl[AUTO_REMOTE_DEFECT_DEFEAT_BIT];
  assign frameGenDisable = q.ctl[FRAME_GEN_DISABLE_BIT];
  assign txAlarmSignalInsert = q.ctl[TX_ALARM_SIGNAL_INSERT_BIT];
  assign cparErrContinuous = q.eir[CPAR_ERR_CONTINUOUS_BIT];
  assign cparErrEnable = q.eir[CPAR_ERR_ENABLE_BIT];
  assign blockErrContinuous = q.eir[BLOCK_ERR_CONTINUOUS_BIT];
  assign blockErrEnable = q.eir[BLOCK_ERR_ENABLE_BIT];
  assign pparErrContinuous = q.eir[PPAR_ERR_CONTINUOUS_BIT];
  assign pparErrEnable = q.eir[PPAR_ERR_ENABLE_BIT];
  assign framingErrEnable = q.eir[FRAMING_ERR_ENABLE_BIT];
  assign manualSourceSelect = q.eir[MANUAL_SOURCE_SELECT_BIT];

  assign genOn = ~frameGenDisable;
  assign mf = inStream.valid & inStream.mfStart;
  assign extRise = q.syncB & ~q.extPrev;
  assign bitTrigRise = q.eir[SINGLE_ERROR_TRIGGER_BIT] & ~q.bitTrigPrev;
  // both edge detectors run all the time, so switching the source while a trigger is high fakes no edge
  assign trig = manualSourceSelect ? extRise : bitTrigRise;
  assign aisBit = AIS_PATTERN[2'd3 - q.patCnt];
  assign idleBit = IDLE_PATTERN[2'd3 - q.patCnt];
  // zero on the line means error or alarm, hence the inversions
  assign febeBit = autoBlockErrorDefeat ? ~forcedBlockError
                                        : ~q.febeLast;
  assign rdiBit = autoRemoteDefectDefeat ? ~forcedRemoteDefect
                                         : ~rxAlarm;
  assign status = {6'h00, q.febeLast, ~rdiBit, q.actFr, q.actB, q.actC,
                   q.actP, q.pendFr, q.pendB, q.pendC, q.pendP};

  always_comb begin
    logic d;
    logic [DATA_W-1:0] rd;
    d = inStream.data;
    rd = 16'h0000;
    s = q;

    // register port: if-chain decode, reserved and unmapped read zero
    if (regAddr == TX_FRAME_CONTROL_OFS) begin
      rd = q.ctl;
    end else if (regAddr == TX_ERROR_INSERTION_OFS) begin
      rd = q.eir;
    end else if (regAddr == TX_STATUS_OFS) begin
      rd = status;
    end
    s.rdata = regRd ? rd : 16'h0000;
    if (regWr) begin
      if (regAddr == TX_FRAME_CONTROL_OFS) begin
        s.ctl = regWdata & TX_FRAME_CONTROL_MASK;
      end else if (regAddr == TX_ERROR_INSERTION_OFS) begin
        s.eir = regWdata & TX_ERROR_INSERTION_MASK;
      end
    end

    // trigger sources
    s.syncA = extErrorTriggerIn;
    s.syncB = q.syncA;
    s.extPrev = q.syncB;
    s.bitTrigPrev = q.eir[SINGLE_ERROR_TRIGGER_BIT];

    // a trigger pends until the next multiframe, so repeats merge
    s.pendP = nextPend(q.pendP, pparErrEnable, pparErrContinuous,
                       trig, mf);
    s.pendC = nextPend(q.pendC, cparErrEnable, cparErrContinuous,
                       trig, mf);
    s.pendB = nextPend(q.pendB, blockErrEnable, blockErrContinuous,
                       trig, mf);
    s.pendFr = nextPend(q.pendFr, framingErrEnable, 1'b0,
                        trig, mf);
    s.actP = nextAct(q.actP, q.pendP, pparErrEnable, pparErrContinuous,
                     trig, mf);
    s.actC = nextAct(q.actC, q.pendC, cparErrEnable, cparErrContinuous,
                     trig, mf);
    s.actB = nextAct(q.actB, q.pendB, blockErrEnable, blockErrContinuous,
                     trig, mf);
    s.actFr = nextAct(q.actFr, q.pendFr, framingErrEnable, 1'b0,
                      trig, mf);

    // receive error summary for the block error bits of next multiframe
    s.febeAcc = q.febeAcc | rxParityErr | rxFramingErr;
    if (mf) begin
      s.frType = framing_err_e'(q.eir[FRAMING_ERR_TYPE_LSB +: 2]);
      s.frDone = 1'b0;
      s.parLast = q.parAcc;
      s.parAcc = 1'b0;
      s.febeLast = s.febeAcc;
      s.febeAcc = 1'b0;
    end

    if (inStream.valid) begin
      case (inStream.pos)
        POS_PAYLOAD: begin
          if (txAlarmSignalInsert) begin
            d = aisBit;
          end else if (txIdleInsert) begin
            d = idleBit;
          end
          s.patCnt = q.patCnt + 2'd1;
          s.parAcc = q.parAcc ^ d;
        end
        POS_X: begin
          if (genOn) begin
            d = rdiBit;
          end
        end
        POS_P: begin
          if (genOn || parityGenEnable) begin
            d = q.parLast;
          end
          if (q.actP) begin
            d = ~d;
          end
        end
        POS_F: begin
          if (genOn) begin
            d = inStream.genBit;
          end
          if (q.actFr && q.frType == FR_F_BIT && !q.frDone) begin
            d = ~d;
            s.frDone = 1'b1;
          end else if (q.actFr && q.frType == FR_SEF &&
                       inStream.subframe == SEF_SUBFRAME) begin
            d = ~d;
          end
        end
        POS_M: begin
          if (genOn) begin
            d = inStream.genBit;
          end
          if (q.actFr && q.frType == FR_M_BIT && !q.frDone) begin
            d = ~d;
            s.frDone = 1'b1;
          end else if (q.actFr && q.frType == FR_OOMF) begin
            d = ~d;
          end
        end
        default: begin
          // c-bit positions
          if (!cbitMode) begin
            if (genOn && !cbitGenDisable) begin
              d = 1'b0;
            end
          end else if (genOn) begin
            if (inStream.pos == POS_C_AIC) begin
              d = 1'b1;
            end else if (inStream.pos == POS_C_PARITY) begin
              d = q.parLast;
            end else if (inStream.pos == POS_C_BLOCK) begin
              d = febeBit;
            end
          end
          if (cbitMode && q.actC && inStream.pos == POS_C_PARITY) begin
            d = ~d;
          end
          if (cbitMode && q.actB && inStream.pos == POS_C_BLOCK) begin
            d = ~d;
          end
        end
      endcase
    end
    s.out = inStream;
    s.out.data = d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctl <= TX_FRAME_CONTROL_RST;
      q.eir <= TX_ERROR_INSERTION_RST;
    end else begin
      q <= s;
    end
  end

  assign regRdata = q.rdata;
  assign outStream = q.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence singleTrigP;
    trig && pparErrEnable && !pparErrContinuous && !mf;
  endsequence

  sequence oppP;
    mf && q.pendP && pparErrEnable;
  endsequence

  a_ppar_gen_value: assert property (
    (inStream.valid && inStream.pos == POS_P && parityGenEnable && !q.actP)
    |=> outStream.data == $past(q.parLast))
    else $error("p-bit not generated parity");

  a_idle_payload: assert property (
    (inStream.valid && inStream.pos == POS_PAYLOAD && txIdleInsert &&
     !txAlarmSignalInsert) |=> outStream.data == $past(idleBit))
    else $error("idle pattern missing");

  a_cbit_zero_fill: assert property (
    (inStream.valid && !cbitMode && inStream.pos >= POS_C_AIC && genOn &&
     !cbitGenDisable) |=> !outStream.data)
    else $error("m23 c-bit not zero");

  a_block_err_forced: assert property (
    (inStream.valid && cbitMode && inStream.pos == POS_C_BLOCK && genOn &&
     autoBlockErrorDefeat && !q.actB)
    |=> outStream.data == !$past(forcedBlockError))
    else $error("forced block error bit wrong");

  a_xbit_forced: assert property (
    (inStream.valid && inStream.pos == POS_X && genOn &&
     autoRemoteDefectDefeat) |=> outStream.data == !$past(forcedRemoteDefect))
    else $error("forced x-bit wrong");

  a_frame_pass: assert property (
    (inStream.valid && inStream.pos == POS_F && frameGenDisable && !q.actFr)
    |=> outStream.data == $past(inStream.data))
    else $error("f-bit not passed through");

  a_ais_payload: assert property (
    (inStream.valid && inStream.pos == POS_PAYLOAD && txAlarmSignalInsert)
    |=> outStream.data == $past(aisBit) && outStream.valid)
    else $error("ais pattern missing");

  a_single_arm: assert property (
    singleTrigP |=> q.pendP)
    else $error("single trigger not held pending");

  a_single_once: assert property (
    oppP |=> q.actP && !q.pendP)
    else $error("single error not armed once");

  a_framing_gate: assert property (
    !framingErrEnable |=> !q.actFr && !q.pendFr)
    else $error("framing error armed while disabled");

  a_ext_edge_arm: assert property (
    (manualSourceSelect && q.syncB && !q.extPrev && pparErrEnable &&
     !pparErrContinuous && !mf) |=> q.pendP)
    else $error("external edge lost");

  a_cont_rearm: assert property (
    (mf && pparErrEnable && pparErrContinuous && !regWr) |=> q.actP [*2])
    else $error("continuous p error not armed");

  a_ppar_pass: assert property (
    (inStream.valid && inStream.pos == POS_P && frameGenDisable &&
     !parityGenEnable && !q.actP) |=> outStream.data == $past(inStream.data))
    else $error("p-bit not passed through");

  a_cbit_pass: assert property (
    (inStream.valid && !cbitMode && inStream.pos >= POS_C_AIC &&
     cbitGenDisable) |=> outStream.data == $past(inStream.data))
    else $error("m23 c-bit not passed through");

  a_block_err_auto: assert property (
    (inStream.valid && cbitMode && inStream.pos == POS_C_BLOCK && genOn &&
     !autoBlockErrorDefeat && !q.actB)
    |=> outStream.data == !$past(q.febeLast))
    else $error("automatic block error bit wrong");

  a_xbit_auto: assert property (
    (inStream.valid && inStream.pos == POS_X && genOn &&
     !autoRemoteDefectDefeat) |=> outStream.data == !$past(rxAlarm))
    else $error("automatic x-bit wrong");

  a_cpar_invert: assert property (
    (inStream.valid && cbitMode && inStream.pos == POS_C_PARITY && genOn &&
     q.actC) |=> outStream.data == !$past(q.parLast))
    else $error("c-parity error not inserted");

  a_block_invert: assert property (
    (inStream.valid && cbitMode && inStream.pos == POS_C_BLOCK && genOn &&
     q.actB) |=> outStream.data == !$past(febeBit))
    else $error("block error not inserted");

  a_single_clear: assert property (
    (mf && q.actP && !q.pendP && !trig && !pparErrContinuous)
    |=> !q.actP)
    else $error("single p error outlived its multiframe");

  a_cont_cpar: assert property (
    (mf && cparErrEnable && cparErrContinuous) |=> q.actC)
    else $error("continuous c error not armed");

endmodule : ds3_tx_framer_overhead_error_insert

// file: src/ds3_tx_pkg.sv
// constants, stream carriers and state type of the ds3 transmit overhead block
package ds3_tx_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] TX_FRAME_CONTROL_OFS = 9'h118;
  localparam logic [ADDR_W-1:0] TX_ERROR_INSERTION_OFS = 9'h11a;
  localparam logic [ADDR_W-1:0] RESERVED_A_OFS = 9'h11c;
  localparam logic [ADDR_W-1:0] RESERVED_B_OFS = 9'h11e;
  localparam logic [ADDR_W-1:0] TX_STATUS_OFS = 9'h1fe;

  // reset values and writable masks
  localparam logic [DATA_W-1:0] TX_FRAME_CONTROL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TX_ERROR_INSERTION_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TX_FRAME_CONTROL_MASK = 16'h1c3f;
  localparam logic [DATA_W-1:0] TX_ERROR_INSERTION_MASK = 16'h0f7f;

  // tx_frame_control fields
  localparam int PARITY_GEN_ENABLE_BIT = 12;
  localparam int TX_IDLE_INSERT_BIT = 11;
  localparam int CBIT_GEN_DISABLE_BIT = 10;
  localparam int FORCED_BLOCK_ERROR_BIT = 5;
  localparam int AUTO_BLOCK_ERROR_DEFEAT_BIT = 4;
  localparam int FORCED_REMOTE_DEFECT_BIT = 3;
  localparam int AUTO_REMOTE_DEFECT_DEFEAT_BIT = 2;
  localparam int FRAME_GEN_DISABLE_BIT = 1;
  localparam int TX_ALARM_SIGNAL_INSERT_BIT = 0;

  // tx_error_insertion fields
  localparam int CPAR_ERR_CONTINUOUS_BIT = 11;
  localparam int CPAR_ERR_ENABLE_BIT = 10;
  localparam int BLOCK_ERR_CONTINUOUS_BIT = 9;
  localparam int BLOCK_ERR_ENABLE_BIT = 8;
  localparam int PPAR_ERR_CONTINUOUS_BIT = 6;
  localparam int PPAR_ERR_ENABLE_BIT = 5;
  localparam int FRAMING_ERR_TYPE_LSB = 3;
  localparam int FRAMING_ERR_ENABLE_BIT = 2;
  localparam int SINGLE_ERROR_TRIGGER_BIT = 1;
  localparam int MANUAL_SOURCE_SELECT_BIT = 0;

  // payload patterns, sent msb first
  localparam logic [3:0] AIS_PATTERN = 4'ha;
  localparam logic [3:0] IDLE_PATTERN = 4'hc;
  localparam logic [2:0] SEF_SUBFRAME = 3'h0;

  typedef enum logic [3:0] {
    POS_PAYLOAD = 4'h0,
    POS_X = 4'h1,
    POS_P = 4'h2,
    POS_M = 4'h3,
    POS_F = 4'h4,
    POS_C_AIC = 4'h5,
    POS_C_PARITY = 4'h6,
    POS_C_BLOCK = 4'h7,
    POS_C_OTHER = 4'h8
  } bit_pos_e;

  typedef enum logic [1:0] {
    FR_F_BIT = 2'h0,
    FR_M_BIT = 2'h1,
    FR_SEF = 2'h2,
    FR_OOMF = 2'h3
  } framing_err_e;

  typedef struct packed {
    logic valid;
    logic data;
    bit_pos_e pos;
    logic mfStart;
    logic [2:0] subframe;
    logic genBit;
  } ds3_bit_s;

  typedef struct packed {
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] eir;
    logic [DATA_W-1:0] rdata;
    logic syncA;
    logic syncB;
    logic extPrev;
    logic bitTrigPrev;
    logic pendP;
    logic pendC;
    logic pendB;
    logic pendFr;
    logic actP;
    logic actC;
    logic actB;
    logic actFr;
    framing_err_e frType;
    logic frDone;
    logic parAcc;
    logic parLast;
    logic febeAcc;
    logic febeLast;
    logic [1:0] patCnt;
    ds3_bit_s out;
  } tx_state_s;

endpackage : ds3_tx_pkg

// file: bench/ds3_line_model.sv
// line side model: frame source and capture of the sent stream
`timescale 1ns/100ps
module ds3_line_model
  import ds3_tx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire ds3_tx_pkg::ds3_bit_s outStream,
  output ds3_tx_pkg::ds3_bit_s inStream,
  output logic [48:0] last,
  output logic [15:0] mfCnt
);
  logic [5:0] idx;
  logic [5:0] oIdx;
  logic [5:0] oPos;
  logic [48:0] cur;
  logic [2:0] sf;
  logic [2:0] k;
  assign sf = 3'(idx / 6'd7);
  assign k = 3'(idx % 6'd7);
  assign oPos = outStream.mfStart ? 6'd0 : oIdx + 6'd1;
  // seven bits a subframe: header, f, c, f, three payload bits
  // overhead inputs differ from nominal so pass-through shows
  always_comb begin
    inStream = '0;
    inStream.valid = 1'b1;
    inStream.mfStart = idx == 6'd0;
    inStream.subframe = sf;
    inStream.data = 1'b1;
    case (k)
      3'd0: begin
        inStream.pos = sf < 3'd2 ? POS_X : sf < 3'd4 ? POS_P : POS_M;
        inStream.genBit = sf == 3'd5;
        inStream.data = sf < 3'd2 || sf == 3'd4 || sf == 3'd6;
      end
      3'd1, 3'd3: begin
        inStream.pos = POS_F;
        inStream.genBit = k == 3'd1;
        inStream.data = k != 3'd1;
      end
      3'd2: begin
        inStream.pos = sf == 3'd0 ? POS_C_AIC : sf == 3'd2 ? POS_C_PARITY :
                       sf == 3'd3 ? POS_C_BLOCK : POS_C_OTHER;
      end
      default: inStream.pos = POS_PAYLOAD;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= '0;
      oIdx <= '0;
      cur <= '0;
      last <= '0;
      mfCnt <= '0;
    end else begin
      idx <= idx == 6'd48 ? 6'd0 : idx + 6'd1;
      if (outStream.valid) begin
        oIdx <= oPos;
        cur[oPos] <= outStream.data;
        if (oPos == 6'd48) begin
          last <= cur;
          last[48] <= outStream.data;
          mfCnt <= mfCnt + 16'h0001;
        end
      end
    end
  end
endmodule : ds3_line_model

// file: bench/testbench.sv
// self-checking bench of the ds3 transmit overhead block
`timescale 1ns/100ps
module testbench;
  import ds3_tx_pkg::*;
  localparam logic [8:0] CTL = TX_FRAME_CONTROL_OFS;
  localparam logic [8:0] EIR = TX_ERROR_INSERTION_OFS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] regAddr = '0;
  logic [15:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic cbitMode = 1'b0;
  logic rxParityErr = 1'b0;
  logic rxFramingErr = 1'b0;
  logic rxAlarm = 1'b0;
  logic extErrorTriggerIn = 1'b0;
  ds3_bit_s inStream;
  ds3_bit_s outStream;
  logic [48:0] mf;
  logic [15:0] mfc;
  logic [15:0] rv;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  ds3_tx_framer_overhead_error_insert
    ds3_tx_framer_overhead_error_insert_inst (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cbitMode(cbitMode),
    .rxParityErr(rxParityErr), .rxFramingErr(rxFramingErr),
    .rxAlarm(rxAlarm), .extErrorTriggerIn(extErrorTriggerIn),
    .inStream(inStream), .outStream(outStream));
  ds3_line_model ds3_line_model_inst (.clk(clk), .rst_n(rst_n),
    .outStream(outStream), .inStream(inStream), .last(mf), .mfCnt(mfc));
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // returns just after the model finished n further multiframes
  task automatic waitMf(input int n);
    logic [15:0] c;
    repeat (n) begin
      c = mfc;
      while (mfc === c) @(posedge clk);
    end
    #1;
  endtask : waitMf
  function automatic logic [48:0] bm(input int a, input int b, input int c);
    bm = '0;
    if (a > 0) bm[a] = 1'b1;
    if (b > 0) bm[b] = 1'b1;
    if (c > 0) bm[c] = 1'b1;
  endfunction : bm
  task automatic ovh(input logic [15:0] ctl, input int i, input logic e);
    wr(CTL, ctl);
    waitMf(2);
    check(mf[i], e);
  endtask : ovh
  task automatic rxErr(input bit fr);
    waitMf(1);
    if (fr) rxFramingErr <= 1'b1;
    else rxParityErr <= 1'b1;
    @(posedge clk);
    rxFramingErr <= 1'b0;
    rxParityErr <= 1'b0;
    waitMf(2);
    check(mf[23], 1'b0);
    waitMf(1);
    check(mf[23], 1'b1);
  endtask : rxErr
  // m1: change in the next multiframe, m2: in the one after it
  task automatic errCase(input logic [15:0] e, input logic [48:0] m1,
                         input logic [48:0] m2, input bit ext);
    logic [48:0] base;
    waitMf(2);
    base = mf;
    wr(EIR, e);
    if (ext) begin
      extErrorTriggerIn <= 1'b1;
      repeat (4) @(posedge clk);
      extErrorTriggerIn <= 1'b0;
    end else begin
      wr(EIR, e | 16'h0002);
      wr(EIR, e);
      wr(EIR, e | 16'h0002);
    end
    // only single-mode kinds wait as pending until the next multiframe
    rd(TX_STATUS_OFS, rv);
    check(rv, {12'h000, e[2], e[8] & ~e[9], e[10] & ~e[11],
               e[5] & ~e[6]});
    waitMf(2);
    check(mf ^ base, m1);
    // single errors have expired, continuous ones stay armed
    rd(TX_STATUS_OFS, rv);
    check(rv, {9'h000, e[8] & e[9], e[10] & e[11], e[5] & e[6],
               4'h0});
    waitMf(1);
    check(mf ^ base, m2);
    wr(EIR, 16'h0000);
  endtask : errCase
  task automatic tRegs;
    rd(CTL, rv);
    check(rv, 16'h0000);
    rd(EIR, rv);
    check(rv, 16'h0000);
    wr(CTL, 16'hffff);
    rd(CTL, rv);
    check(rv, 16'h1c3f);
    // source select kept low so the trigger bit may move freely
    wr(EIR, 16'hfffe);
    rd(EIR, rv);
    check(rv, 16'h0f7e);
    wr(9'h11c, 16'hffff);
    rd(9'h11c, rv);
    check(rv, 16'h0000);
    rd(9'h100, rv);
    check(rv, 16'h0000);
    wr(EIR, 16'h0000);
    wr(CTL, 16'h0000);
    waitMf(2);
    $display("register test done");
  endtask : tRegs
  task automatic tOvh;
    ovh(16'h0000, 2, 1'b0);
    ovh(16'h0400, 2, 1'b1);
    ovh(16'h0000, 1, 1'b1);
    check(mf[14], 1'b1);
    ovh(16'h0002, 1, 1'b0);
    ovh(16'h0002, 14, 1'b0);
    ovh(16'h1002, 14, 1'b1);
    ovh(16'h000c, 0, 1'b0);
    ovh(16'h0004, 7, 1'b1);
    cbitMode <= 1'b1;
    ovh(16'h0030, 23, 1'b0);
    ovh(16'h0010, 23, 1'b1);
    ovh(16'h0000, 23, 1'b1);
    $display("overhead test done");
  endtask : tOvh
  task automatic tAuto;
    rxErr(1'b0);
    rxErr(1'b1);
    rxAlarm <= 1'b1;
    waitMf(3);
    check(mf[0], 1'b0);
    rxAlarm <= 1'b0;
    waitMf(3);
    check(mf[7], 1'b1);
    $display("auto indication test done");
  endtask : tAuto
  task automatic tPay;
    wr(CTL, 16'h0001);
    waitMf(2);
    check((mf[4] ^ mf[5]) & (mf[5] ^ mf[6]), 1'b1);
    wr(CTL, 16'h0800);
    waitMf(2);
    check((mf[4] ^ mf[5]) & (mf[5] ^ mf[6]), 1'b0);
    check(&{mf[4], mf[5], mf[6]}, 1'b0);
    wr(CTL, 16'h0000);
    waitMf(2);
    check({mf[4], mf[5], mf[6]}, 3'h7);
    $display("payload test done");
  endtask : tPay
  task automatic tErr;
    errCase(16'h0020, bm(14, 21, 0), '0, 0);
    errCase(16'h0060, bm(14, 21, 0), bm(14, 21, 0), 0);
    errCase(16'h0400, bm(16, 0, 0), '0, 0);
    errCase(16'h0c00, bm(16, 0, 0), bm(16, 0, 0), 0);
    errCase(16'h0100, bm(23, 0, 0), '0, 0);
    errCase(16'h0300, bm(23, 0, 0), bm(23, 0, 0), 0);
    errCase(16'h0004, bm(1, 0, 0), '0, 0);
    errCase(16'h000c, bm(28, 0, 0), '0, 0);
    errCase(16'h0014, bm(1, 3, 0), '0, 0);
    errCase(16'h001c, bm(28, 35, 42), '0, 0);
    errCase(16'h0018, '0, '0, 0);
    errCase(16'h0021, bm(14, 21, 0), '0, 1);
    $display("error insertion test done");
  endtask : tErr
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_fail++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tRegs();
    tOvh();
    tAuto();
    tPay();
    tErr();
    summarize();
  end
endmodule : testbench
